/* File: shared/alcr_consts.vh */
// Constants for the ambient light conversion readout block.
// Assumes a 250 MHz reference clock and a 7-bit I2C target address.
`ifndef ALCR_CONSTS_VH
`define ALCR_CONSTS_VH

// Bus addresses
`define ALCR_DEV_ADDR 7'h13
`define ALCR_REG_CFG 8'h84
`define ALCR_REG_RES_HI 8'h85
`define ALCR_REG_RES_LO 8'h86
`define ALCR_REG_AVG 8'h87
// Config fields
`define ALCR_CFG_CONT_BIT 7
`define ALCR_CFG_RST 8'h00
`define ALCR_AVG_RST 8'h00
`define ALCR_AVG_MAX 8'h07
// Timing, in ns and cycles of a 4 ns clock
`define ALCR_CLK_NS 4
`define ALCR_FRAME_NS 100000000
`define ALCR_CONV_NS 300000
`define ALCR_FRAME_CYC (`ALCR_FRAME_NS / `ALCR_CLK_NS)
`define ALCR_CONV_CYC (`ALCR_CONV_NS / `ALCR_CLK_NS)

`endif

/* File: hw/alcr_top.v */
// Ambient light conversion sequencer with I2C register readout.
// Assumes SCL/SDA pins asynchronous to REF_CLK, an ADC sample input valid each conversion end.
// Summary of operation
// - After addressing, a read address returns high result byte from that register.
// - A following read byte returns the low result byte at the next address.
// - Config bit 7 picks standard mode when 0, continuous conversion when 1.
// - Standard mode runs each measurement cycle inside a fixed 100 ms frame.
// - One conversion takes about 300 us; rest of standard frame is idle.
// - Result is average of a programmable conversion count, up to 128.
// - Standard mode publishes the averaged result only when the frame elapses.
// - Continuous mode starts each conversion right after the previous ends.
// - Register pointer advances after every read data byte.
// - Stop then start or repeated start both accepted between address and read.
`include "alcr_consts.vh"
`default_nettype none

module alcr_top #(
  parameter FRAME_CYC = `ALCR_FRAME_CYC,
  parameter CONV_CYC = `ALCR_CONV_CYC
) (
  // Clock and reset
  input wire REF_CLK,
  input wire NRST,
  // I2C pins
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  // Light sensor front end
  input wire [15:0] ADC_SAMPLE,
  output reg CONV_ACTIVE
);

  // ==========================================================
  // Reset release
  reg [1:0] rst_sync;
  wire rst_n = rst_sync[1];
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end

  // ==========================================================
  // Pin synchronisers and edge detect
  reg [1:0] scl_s, sda_s;
  reg scl_d, sda_d;
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], SCL_IN};
      sda_s <= {sda_s[0], SDA_IN};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end
  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c = scl & scl_d & sda_d & ~sda;
  wire stop_c = scl & scl_d & ~sda_d & sda;

  // ==========================================================
  // Registers
  reg [7:0] cfg, avg_sel, res_hi, res_lo, ptr;

  function [7:0] reg_read;
    input [7:0] a;
    begin
      case (a)
        `ALCR_REG_CFG: reg_read = cfg;
        `ALCR_REG_RES_HI: reg_read = res_hi;
        `ALCR_REG_RES_LO: reg_read = res_lo;
        `ALCR_REG_AVG: reg_read = avg_sel;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // ==========================================================
  // I2C target
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_AACK = 3'h2;
  localparam S_WBYTE = 3'h3;
  localparam S_WACK = 3'h4;
  localparam S_RBYTE = 3'h5;
  localparam S_RACK = 3'h6;
  reg [2:0] st;
  reg [3:0] bitc;
  reg [7:0] sh;
  reg rd, first_w;
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st <= S_IDLE;
      bitc <= 4'h0;
      sh <= 8'h00;
      rd <= 1'b0;
      first_w <= 1'b0;
      ptr <= 8'h00;
      cfg <= `ALCR_CFG_RST;
      avg_sel <= `ALCR_AVG_RST;
      SDA_OUT <= 1'b1;
      SDA_OE <= 1'b0;
    end else if (start_c) begin
      st <= S_ADDR;
      bitc <= 4'h0;
      SDA_OE <= 1'b0;
    end else if (stop_c) begin
      st <= S_IDLE;
      SDA_OE <= 1'b0;
    end else begin
      case (st)
        S_IDLE: SDA_OE <= 1'b0;
        S_ADDR: begin
          if (scl_rise) begin
            sh <= {sh[6:0], sda};
            bitc <= bitc + 4'h1;
          end
          if (scl_fall && bitc == 4'h8) begin
            if (sh[7:1] == `ALCR_DEV_ADDR) begin
              rd <= sh[0];
              first_w <= 1'b1;
              SDA_OUT <= 1'b0;
              SDA_OE <= 1'b1;
              st <= S_AACK;
            end else begin
              st <= S_IDLE;
            end
          end
        end
        S_AACK, S_WACK: begin
          if (scl_fall) begin
            bitc <= 4'h0;
            if (rd) begin
              sh <= reg_read(ptr);
              SDA_OUT <= reg_read(ptr) >> 7 == 8'h01;
              SDA_OE <= 1'b1;
              st <= S_RBYTE;
            end else begin
              SDA_OE <= 1'b0;
              st <= S_WBYTE;
            end
          end
        end
        S_WBYTE: begin
          if (scl_rise) begin
            sh <= {sh[6:0], sda};
            bitc <= bitc + 4'h1;
          end
          if (scl_fall && bitc == 4'h8) begin
            if (first_w) begin
              ptr <= sh;
              first_w <= 1'b0;
            end else begin
              if (ptr == `ALCR_REG_CFG) cfg <= sh;
              if (ptr == `ALCR_REG_AVG) avg_sel <= sh;
              ptr <= ptr + 8'h01;
            end
            SDA_OUT <= 1'b0;
            SDA_OE <= 1'b1;
            st <= S_WACK;
          end
        end
        S_RBYTE: begin
          if (scl_rise) bitc <= bitc + 4'h1;
          if (scl_fall) begin
            if (bitc == 4'h8) begin
              SDA_OE <= 1'b0;
              ptr <= ptr + 8'h01;
              st <= S_RACK;
            end else begin
              sh <= {sh[6:0], 1'b0};
              SDA_OUT <= sh[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            if (sda) st <= S_IDLE;
            else st <= S_AACK;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Conversion sequencer
  reg [24:0] frame_cnt;
  reg [16:0] conv_cnt;
  reg [7:0] done_n;
  reg [22:0] acc;
  reg frame_busy;
  reg cont_d;
  wire cont = cfg[`ALCR_CFG_CONT_BIT];
  wire [2:0] avg_log = (avg_sel > `ALCR_AVG_MAX) ? 3'h7 : avg_sel[2:0];
  wire [7:0] avg_n = 8'h01 << avg_log;
  wire conv_end = CONV_ACTIVE && conv_cnt == CONV_CYC - 1;
  wire last = done_n + 8'h01 == avg_n;
  wire [22:0] sum = acc + {7'h00, ADC_SAMPLE};
  wire [22:0] mean = sum >> avg_log;
  wire [22:0] acc_mean = acc >> avg_log;
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt <= 25'h000_0000;
      conv_cnt <= 17'h0_0000;
      done_n <= 8'h00;
      acc <= 23'h00_0000;
      frame_busy <= 1'b0;
      cont_d <= 1'b0;
      CONV_ACTIVE <= 1'b0;
      res_hi <= 8'h00;
      res_lo <= 8'h00;
    end else begin
      conv_cnt <= CONV_ACTIVE && !conv_end ? conv_cnt + 17'h0_0001 : 17'h0_0000;
      cont_d <= cont;
      if (cont) begin
        frame_cnt <= 25'h000_0000;
        frame_busy <= 1'b0;
        CONV_ACTIVE <= 1'b1;
        if (!cont_d) begin
          // Fresh average on mode entry, no stale count
          conv_cnt <= 17'h0_0000;
          acc <= 23'h00_0000;
          done_n <= 8'h00;
        end else if (conv_end) begin
          if (last) begin
            {res_hi, res_lo} <= mean[15:0];
            acc <= 23'h00_0000;
            done_n <= 8'h00;
          end else begin
            acc <= sum;
            done_n <= done_n + 8'h01;
          end
        end
      end else begin
        frame_cnt <= frame_cnt == FRAME_CYC - 1 ? 25'h000_0000 : frame_cnt + 25'h000_0001;
        if (frame_cnt == 25'h000_0000) begin
          frame_busy <= 1'b1;
          CONV_ACTIVE <= 1'b1;
          conv_cnt <= 17'h0_0000;
          acc <= 23'h00_0000;
          done_n <= 8'h00;
        end else if (conv_end && frame_busy) begin
          acc <= sum;
          done_n <= done_n + 8'h01;
          if (last) begin
            frame_busy <= 1'b0;
            CONV_ACTIVE <= 1'b0;
          end
        end
        if (frame_cnt == FRAME_CYC - 1) begin
          {res_hi, res_lo} <= acc_mean[15:0];
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: verif/alcr_assertions.sv */
// Checker for pin and conversion timing of the light readout.
// Assumes it is bound to alcr_top.
`default_nettype none
module alcr_checker #(
  parameter FRAME_CYC = 2000,
  parameter CONV_CYC = 50
) (
  // Watched ports
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic CONV_ACTIVE
);
  // ==========
  // Counters
  int run;
  int gap;
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      run <= 0;
      gap <= 0;
    end else begin
      run <= CONV_ACTIVE ? run + 1 : 0;
      gap <= CONV_ACTIVE ? 0 : gap + 1;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // ==========
  // Properties
  a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("enable moved, clock high");
  a_data_scl_low: assert property (SDA_OE && $changed(SDA_OUT) |-> !SCL_IN)
    else $error("data moved, clock high");
  a_oe_holds: assert property ($rose(SDA_OE) |=> SDA_OE[*8])
    else $error("drive too short");
  a_free_at_stop: assert property (SCL_IN && $rose(SDA_IN) |-> !SDA_OE)
    else $error("driving at stop");
  a_free_at_start: assert property (SCL_IN && $fell(SDA_IN) |-> !SDA_OE)
    else $error("driving at start");
  a_conv_length: assert property ($fell(CONV_ACTIVE) |-> run != 0 && run % CONV_CYC == 0)
    else $error("conversion length");
  a_frame_gap: assert property ($rose(CONV_ACTIVE) |-> gap < FRAME_CYC)
    else $error("idle beyond frame");
  a_reset_quiet: assert property ($rose(NRST) |-> (!SDA_OE && !CONV_ACTIVE)[*2])
    else $error("active after reset");
  c_conv: cover property ($fell(CONV_ACTIVE));
  c_drive: cover property ($rose(SDA_OE));
  c_stop: cover property (SCL_IN && $rose(SDA_IN));
endmodule
bind alcr_top alcr_checker #(.FRAME_CYC(FRAME_CYC), .CONV_CYC(CONV_CYC)) chk_u (
  .REF_CLK(REF_CLK), .NRST(NRST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CONV_ACTIVE(CONV_ACTIVE));
`default_nettype wire

/* File: verif/alcr_i2c_host.sv */
// I2C host model driving SCL and SDA.
// Assumes a pull-up: sda high means released.
`default_nettype none
module alcr_i2c_host (
  // Clock and wire
  input wire logic clk,
  input wire logic sda_wire,
  // Host drive
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hold();
    repeat (10) @(posedge clk);
  endtask
  task automatic start();
    sda <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda <= 1'b0;
    hold();
    scl <= 1'b0;
  endtask
  task automatic stop();
    hold();
    sda <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda <= 1'b1;
    hold();
  endtask
  // Byte then acknowledge; 1 releases
  task automatic xfer(input logic [7:0] w, input logic ak, output logic [7:0] r,
      output logic a);
    for (int i = 8; i >= 0; i--) begin
      hold();
      sda <= (i == 0) ? ak : w[i - 1];
      hold();
      scl <= 1'b1;
      hold();
      if (i == 0) a = sda_wire;
      else r[i - 1] = sda_wire;
      scl <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/test_ambient_light_conversion_readout.sv */
// Testbench for the light readout over I2C.
// Assumes alcr_top and the host model.
`default_nettype none
module test_ambient_light_conversion_readout;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRAME = 8000;
  localparam int CONV = 40;
  logic REF_CLK = 1'b0;
  logic NRST = 1'b0;
  logic [15:0] ADC_SAMPLE = 16'h1000;
  logic [15:0] val_a = 16'h1000;
  logic [15:0] val_b = 16'h3000;
  wire SDA_OUT, SDA_OE, CONV_ACTIVE, scl, sda_h;
  wire sda_wire = sda_h & (SDA_OE ? SDA_OUT : 1'b1);
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int cnt = 0;
  int avg[2] = '{1, 7};
  always #2 REF_CLK = ~REF_CLK;
  alcr_top #(.FRAME_CYC(FRAME), .CONV_CYC(CONV)) dut_u (.REF_CLK(REF_CLK), .NRST(NRST),
    .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .ADC_SAMPLE(ADC_SAMPLE), .CONV_ACTIVE(CONV_ACTIVE));
  alcr_i2c_host host (.clk(REF_CLK), .sda_wire(sda_wire), .scl(scl), .sda(sda_h));
  // Alternating samples and timeout
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    cnt <= (CONV_ACTIVE && cnt < CONV - 1) ? cnt + 1 : 0;
    if (CONV_ACTIVE && cnt == CONV - 1) ADC_SAMPLE <= (ADC_SAMPLE == val_a) ? val_b : val_a;
    if (cyc == 90000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic [7:0] r;
    logic a;
    host.start();
    host.xfer(8'h26, 1'b1, r, a);
    host.xfer(ra, 1'b1, r, a);
    host.xfer(d, 1'b1, r, a);
    check("write ack", 16'(a), 16'h0000);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] ra, input logic sp, output logic [15:0] v);
    logic [7:0] r;
    logic a;
    host.start();
    host.xfer(8'h26, 1'b1, r, a);
    host.xfer(ra, 1'b1, r, a);
    if (sp) host.stop();
    host.start();
    host.xfer(8'h27, 1'b1, r, a);
    check("read ack", 16'(a), 16'h0000);
    host.xfer(8'hFF, 1'b0, v[15:8], a);
    host.xfer(8'hFF, 1'b1, v[7:0], a);
    host.stop();
  endtask
  task automatic point(input logic [7:0] ra);
    logic [7:0] r;
    logic a;
    host.start();
    host.xfer(8'h26, 1'b1, r, a);
    host.xfer(ra, 1'b1, r, a);
    host.stop();
  endtask
  task automatic rd_one(output logic [7:0] b);
    logic [7:0] r;
    logic a;
    host.start();
    host.xfer(8'h27, 1'b1, r, a);
    host.xfer(8'hFF, 1'b1, b, a);
    host.stop();
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    logic [15:0] v;
    logic [7:0] b;
    int low;
    repeat (4) @(posedge REF_CLK);
    NRST <= 1'b1;
    repeat (6) @(posedge REF_CLK);
    rd(8'h85, 1'b0, v);
    check("early", 16'(v inside {16'h1000, 16'h3000}), 16'h0000);
    repeat (FRAME) @(posedge REF_CLK);
    rd(8'h85, 1'b1, v);
    check("single", v, val_a);
    point(8'h85);
    rd_one(b);
    check("next high", {8'h00, b}, {8'h00, val_a[15:8]});
    rd_one(b);
    check("next low", {8'h00, b}, {8'h00, val_a[7:0]});
    foreach (avg[i]) begin
      wr(8'h87, 8'(avg[i]));
      repeat (2 * FRAME) @(posedge REF_CLK);
      rd(8'h85, i[0], v);
      check("average", v, 16'h2000);
    end
    rd(8'h90, 1'b0, v);
    check("unmapped", v, 16'h0000);
    val_a <= 16'h0400;
    val_b <= 16'h0C00;
    wr(8'h87, 8'h01);
    wr(8'h84, 8'h80);
    repeat (CONV + 4) @(posedge REF_CLK);
    low = 0;
    repeat (4 * CONV) @(negedge REF_CLK) low += int'(!CONV_ACTIVE);
    check("gap", 16'(low != 0), 16'h0000);
    rd(8'h85, 1'b1, v);
    check("continuous", v, 16'h0800);
    summarize();
  end
endmodule
`default_nettype wire
